// file: logic/rcbc_map.svh
// Register offsets, field positions and reset values of the calibration and backup control block
`ifndef RCBC_MAP_SVH
`define RCBC_MAP_SVH
// ==========================================
// Register offsets
`define RCBC_OFS_CTRL   4'h0
`define RCBC_OFS_CAL    4'h1
`define RCBC_OFS_CFG    4'hE
`define RCBC_OFS_STAT   4'hF
// ==========================================
// Control register fields
`define RCBC_CTRL_CAL   2
`define RCBC_CTRL_AEN   3
// Calibration register fields
`define RCBC_CAL_SIGN   5
`define RCBC_CAL_MAG_HI 4
// Configuration register fields
`define RCBC_CFG_ALSW   7
`define RCBC_CFG_F1     6
`define RCBC_CFG_F0     5
`define RCBC_CFG_TEN    2
`define RCBC_CFG_FC     1
// ==========================================
// Reset values
`define RCBC_RST_CTRL   2'h0
`define RCBC_RST_MAG    5'h00
`define RCBC_RST_CFG    8'h80
// ==========================================
// Divider taps and pin input indices
`define RCBC_TAP_512    5
`define RCBC_TAP_4096   2
`define RCBC_TAP_1HZ    14
`define RCBC_PIN_XTAL   0
`define RCBC_PIN_VLOW   1
`define RCBC_PIN_VFULL  2
`define RCBC_PIN_LOST   3
`endif

// file: logic/rcbc_pkg.sv
// Types shared by the calibration and backup control block
package rcbc_pkg;
    // ==========================================
    // Data byte of the register port
    typedef logic [7:0] rcbc_byte_t;
    // Register address
    typedef logic [3:0] rcbc_addr_t;
    // Function that owns the multifunction pin
    typedef enum logic [1:0] {
        RCBC_MOP_CAL,
        RCBC_MOP_WAVE,
        RCBC_MOP_ALARM,
        RCBC_MOP_HIZ
    } rcbc_mop_t;
endpackage

// file: logic/rcbc_ctrl.sv
// Calibration, timebase correction, pin mux and backup supply control of the clock
// Summary of operation
// - Calibration bit gives pin to calibration
// - Calibration drives raw 512 Hz square wave
// - Correction removes or adds divider pulses
// - Sign one adds, sign zero removes pulses
// - Five-bit magnitude, zero means no correction
// - Correction writable only in calibration mode
// - Clearing calibration restores selected pin function
// - Correction lost when backup source fails
// - Low main supply switches to backup
// - Trickle enable charges until backup full
// - Fast charge selects high current mode
// - Calibration bit two; alarm keeps running
// - Square wave needs select bit zero
`timescale 1ns/1ps
`include "rcbc_map.svh"

module rcbc_ctrl #(
    parameter int CORR_LOG2 = 18  // Correction interval, log2 of timebase ticks
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire rcbc_pkg::rcbc_addr_t regAddr,
    input  wire rcbc_pkg::rcbc_byte_t regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output rcbc_pkg::rcbc_byte_t   regRdata,
    input  wire logic              xtalIn,
    input  wire logic              vddBelowSw,
    input  wire logic              vbakAtVdd,
    input  wire logic              backupLost,
    input  wire logic              alarmActive,
    output logic                   mopOut,
    output logic                   mopOe,
    output logic                   onBackup,
    output logic                   chargeEn,
    output logic                   fastChargeEn,
    output logic                   secTick
);
    import rcbc_pkg::*;

    // ==========================================
    // Address decode
    function automatic logic hit(input rcbc_addr_t a, input rcbc_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // ==========================================
    // Pin synchronisers
    logic [3:0]       pinRaw;     // Asynchronous inputs gathered
    logic [3:0]       syncA_r;    // First stage, read only by second
    logic [3:0]       syncB_r;    // Synchronised levels
    assign pinRaw = {backupLost, vbakAtVdd, vddBelowSw, xtalIn};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            // Two flops per pin guard against metastability
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    syncA_r[gi] <= 1'b0;
                    syncB_r[gi] <= 1'b0;
                end
                else
                begin
                    syncA_r[gi] <= pinRaw[gi];
                    syncB_r[gi] <= syncA_r[gi];
                end
            end
        end
    endgenerate

    logic             xtalS;      // Synced crystal level
    logic             vddLowS;    // Synced supply comparator
    logic             vbakFullS;  // Synced backup full comparator
    logic             lostS;      // Synced backup lost flag
    assign xtalS     = syncB_r[`RCBC_PIN_XTAL];
    assign vddLowS   = syncB_r[`RCBC_PIN_VLOW];
    assign vbakFullS = syncB_r[`RCBC_PIN_VFULL];
    assign lostS     = syncB_r[`RCBC_PIN_LOST];

    // ==========================================
    // Registers
    logic             calMode_r;  // Calibration mode
    logic             aen_r;      // Alarm enable
    logic             calSign_r;  // cal_sign_bit
    logic [4:0]       calMag_r;   // Correction magnitude
    rcbc_byte_t       cfg_r;      // Configuration register
    logic             wrCtrl;     // Write hits control
    logic             wrCal;      // Write hits correction
    assign wrCtrl = regWr && hit(regAddr, `RCBC_OFS_CTRL);
    assign wrCal  = regWr && hit(regAddr, `RCBC_OFS_CAL);

    // Control register, calibration bit at bit two
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            {aen_r, calMode_r} <= `RCBC_RST_CTRL;
        else if (wrCtrl)
        begin
            calMode_r <= regWdata[`RCBC_CTRL_CAL];
            aen_r     <= regWdata[`RCBC_CTRL_AEN];
        end
    end

    // Correction register; the backup loss wins over a write
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            calSign_r <= 1'b0;
            calMag_r  <= `RCBC_RST_MAG;
        end
        else if (lostS)
        begin
            // Setting gone with its supply, software reloads it
            calSign_r <= 1'b0;
            calMag_r  <= `RCBC_RST_MAG;
        end
        else if (wrCal && calMode_r)
        begin
            calSign_r <= regWdata[`RCBC_CAL_SIGN];
            calMag_r  <= regWdata[`RCBC_CAL_MAG_HI:0];
        end
    end

    // Configuration register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            cfg_r <= `RCBC_RST_CFG;
        else if (regWr && hit(regAddr, `RCBC_OFS_CFG))
            cfg_r <= regWdata;
    end

    // ==========================================
    // Raw timebase divider
    logic             xtalD_r;    // Delayed crystal level
    logic             rawTick;    // One cycle per crystal period
    logic [14:0]      rawCnt_r;   // Uncorrected divider
    assign rawTick = xtalS && !xtalD_r;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            xtalD_r  <= 1'b0;
            rawCnt_r <= 15'h0000;
        end
        else
        begin
            xtalD_r <= xtalS;
            if (rawTick)
                rawCnt_r <= rawCnt_r + 15'h0001;
        end
    end

    logic             raw512;     // Uncorrected 512 Hz wave
    assign raw512 = rawCnt_r[`RCBC_TAP_512];

    // ==========================================
    // Correction interval and pending pulses
    logic [CORR_LOG2-1:0] intCnt_r;   // Interval counter
    logic [4:0]       pending_r;  // Pulses left this interval
    logic             corrNow;    // Correct on this tick
    assign corrNow = rawTick && (pending_r != 5'h00);

    // Magnitude loaded once per interval, one pulse per step
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            intCnt_r  <= '0;
            pending_r <= 5'h00;
        end
        else if (rawTick)
        begin
            intCnt_r <= intCnt_r + 1'b1;
            if (intCnt_r == '1)
                pending_r <= calMag_r;
            else if (corrNow)
                pending_r <= pending_r - 5'h01;
        end
    end

    // ==========================================
    // Corrected divider
    logic [15:0]      corrSum;    // Count plus increment, with carry
    logic [14:0]      corrCnt_r;  // Corrected divider
    logic [1:0]       corrInc;    // Counts added this cycle
    // A removed pulse adds nothing, an added one counts twice
    always_comb
    begin
        corrInc = 2'h0;
        if (rawTick && !corrNow)
            corrInc = 2'h1;
        else if (corrNow && calSign_r)
            corrInc = 2'h2;
    end
    assign corrSum = {1'b0, corrCnt_r} + {14'h0000, corrInc};

    // Carry out marks one corrected second
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            corrCnt_r <= 15'h0000;
            secTick   <= 1'b0;
        end
        else
        begin
            corrCnt_r <= corrSum[14:0];
            secTick   <= corrSum[15];
        end
    end

    // ==========================================
    // Multifunction pin mux
    logic             sqWave;     // Selected square wave
    rcbc_mop_t        mopSel;     // Pin owner
    always_comb
    begin
        unique case ({cfg_r[`RCBC_CFG_F1], cfg_r[`RCBC_CFG_F0]})
            2'h0: sqWave = corrCnt_r[`RCBC_TAP_1HZ];
            2'h1: sqWave = raw512;
            2'h2: sqWave = rawCnt_r[`RCBC_TAP_4096];
            2'h3: sqWave = xtalS;
        endcase
    end

    // Calibration outranks every other function
    always_comb
    begin
        if (calMode_r)
            mopSel = RCBC_MOP_CAL;
        else if (!cfg_r[`RCBC_CFG_ALSW])
            mopSel = RCBC_MOP_WAVE;
        else if (aen_r)
            mopSel = RCBC_MOP_ALARM;
        else
            mopSel = RCBC_MOP_HIZ;
    end

    // Open drain: enable pulls low, registered against glitches
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            mopOe <= 1'b0;
        else
        begin
            unique case (mopSel)
                RCBC_MOP_CAL:   mopOe <= !raw512;
                RCBC_MOP_WAVE:  mopOe <= !sqWave;
                RCBC_MOP_ALARM: mopOe <= alarmActive;
                RCBC_MOP_HIZ:   mopOe <= 1'b0;
            endcase
        end
    end
    assign mopOut = 1'b0;

    // ==========================================
    // Backup switchover and trickle charger
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            onBackup     <= 1'b0;
            chargeEn     <= 1'b0;
            fastChargeEn <= 1'b0;
        end
        else
        begin
            onBackup <= vddLowS;
            // Charge only on main power and until backup is full
            chargeEn <= cfg_r[`RCBC_CFG_TEN] && !vddLowS && !vbakFullS;
            fastChargeEn <= cfg_r[`RCBC_CFG_TEN] && cfg_r[`RCBC_CFG_FC] && !vddLowS && !vbakFullS;
        end
    end

    // ==========================================
    // Read port, data valid the cycle after the strobe
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            regRdata <= 8'h00;
        else if (regRd)
        begin
            regRdata <= 8'h00;
            if (hit(regAddr, `RCBC_OFS_CTRL))
            begin
                regRdata[`RCBC_CTRL_CAL] <= calMode_r;
                regRdata[`RCBC_CTRL_AEN] <= aen_r;
            end
            else if (hit(regAddr, `RCBC_OFS_CAL))
                regRdata <= {2'h0, calSign_r, calMag_r};
            else if (hit(regAddr, `RCBC_OFS_CFG))
                regRdata <= cfg_r;
            else if (hit(regAddr, `RCBC_OFS_STAT))
                regRdata <= {4'h0, fastChargeEn, chargeEn, onBackup, vddLowS};
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_cal_write_block: assert property (wrCal && !calMode_r && !lostS |=> $stable(calMag_r))
        else $error("correction changed outside calibration mode");
    a_cal_write_take: assert property (wrCal && calMode_r && !lostS |=>
        calMag_r == $past(regWdata[`RCBC_CAL_MAG_HI:0]) && calSign_r == $past(regWdata[`RCBC_CAL_SIGN]))
        else $error("correction write not stored");
    a_cal_pin_wave: assert property (calMode_r |=> mopOe == !$past(raw512))
        else $error("pin does not follow raw 512 Hz wave");
    a_skip_pulse: assert property (corrNow && !calSign_r |=> corrCnt_r == $past(corrCnt_r))
        else $error("negative correction did not drop a pulse");
    a_add_pulse: assert property (corrNow && calSign_r |=> corrCnt_r == $past(corrCnt_r) + 15'h0002)
        else $error("positive correction did not add a pulse");
    a_exit_cal: assert property (!calMode_r && !cfg_r[`RCBC_CFG_ALSW] |=> mopOe == !$past(sqWave))
        else $error("pin not returned to square wave");
    a_backup_switch: assert property ($rose(vddLowS) |=> onBackup && !chargeEn)
        else $error("no switch to backup supply");
    a_charge_off: assert property (!cfg_r[`RCBC_CFG_TEN] |=> !chargeEn && !fastChargeEn)
        else $error("charging with trickle disabled");
    a_fast_mode: assert property (fastChargeEn |-> chargeEn && $past(cfg_r[`RCBC_CFG_FC]))
        else $error("fast charge without enabled charger");
    a_lost_clears: assert property (lostS |=> calMag_r == 5'h00 && !calSign_r)
        else $error("correction survived backup loss");

    c_cal_entry: cover property ($rose(calMode_r) ##1 wrCal);
    c_add_pulse: cover property (corrNow && calSign_r);
    c_backup: cover property ($rose(onBackup));
    c_fast: cover property ($rose(fastChargeEn));
endmodule

// file: tb/rcbc_host_model.sv
// Host bus master model that reaches the calibration and backup registers
`timescale 1ns/1ps
`include "rcbc_map.svh"

module rcbc_host_model #(
    parameter bit LITHIUM = 1'b0  // Backup is a lithium cell
) (
    input  wire logic            sys_clk,
    output rcbc_pkg::rcbc_addr_t regAddr,
    output rcbc_pkg::rcbc_byte_t regWdata,
    output logic                 regWr,
    output logic                 regRd,
    input  wire rcbc_pkg::rcbc_byte_t regRdata
);
    import rcbc_pkg::*;

    // ==========================================
    // Idle bus at time zero
    initial
    begin
        regAddr  = 4'h0;
        regWdata = 8'h00;
        regWr    = 1'b0;
        regRd    = 1'b0;
    end

    // ==========================================
    // One write cycle; an edge always passes first, so strobes never stack
    task automatic wr(input rcbc_addr_t a, input rcbc_byte_t d);
        rcbc_byte_t v;
        v = d;
        // A cell must never be charged, so trickle stays off
        if (LITHIUM && a == `RCBC_OFS_CFG) v[`RCBC_CFG_TEN] = 1'b0;
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= v;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask

    // One read cycle; data stand from the cycle after the strobe until the next read, taken at the edge ending that cycle
    task automatic rd(input rcbc_addr_t a, output rcbc_byte_t d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        @(posedge sys_clk);
        d = regRdata;
    endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the calibration and backup control block
`timescale 1ns/1ps
`include "rcbc_map.svh"

module tb_top;
    import rcbc_pkg::*;
    // ==========================================
    // Crystal period in clock cycles; short correction interval
    localparam int XP   = 2;
    localparam int CLOG = 4;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       xtalIn = 1'b0;
    logic       vddBelowSw = 1'b0;
    logic       vbakAtVdd = 1'b0;
    logic       backupLost = 1'b0;
    logic       alarmActive = 1'b0;
    rcbc_addr_t regAddr;
    rcbc_byte_t regWdata;
    logic       regWr;
    logic       regRd;
    rcbc_byte_t regRdata;
    logic       mopOut, mopOe, onBackup, chargeEn, fastChargeEn, secTick;
    int         mCtrl = 0, mCal = 0, mCfg = 'h80;  // Register model
    int         errCount = 0, compares = 0, n;
    int         half[4] = '{0, 32 * XP, 4 * XP, XP / 2};

    rcbc_ctrl #(.CORR_LOG2(CLOG)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .xtalIn(xtalIn),
        .vddBelowSw(vddBelowSw), .vbakAtVdd(vbakAtVdd), .backupLost(backupLost),
        .alarmActive(alarmActive), .mopOut(mopOut), .mopOe(mopOe), .onBackup(onBackup),
        .chargeEn(chargeEn), .fastChargeEn(fastChargeEn), .secTick(secTick));
    rcbc_host_model host_u (.sys_clk(sys_clk), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

    // ==========================================
    // Clocks: crystal is sped up and locked to the clock for exact periods
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) xtalIn <= ~xtalIn;

    // ==========================================
    // Compare and verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            errCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wrapUp;
        $display("Compares %0d, mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Expected read value from the model and the supply levels
    function automatic logic [7:0] expRd(input rcbc_addr_t a);
        logic c;
        c = mCfg[2] & ~vddBelowSw & ~vbakAtVdd;
        case (a)
            `RCBC_OFS_CTRL: return 8'(mCtrl) & 8'h0C;
            `RCBC_OFS_CAL:  return 8'(mCal);
            `RCBC_OFS_CFG:  return 8'(mCfg);
            `RCBC_OFS_STAT: return {4'h0, c & mCfg[1], c, vddBelowSw, vddBelowSw};
            default:        return 8'h00;
        endcase
    endfunction

    // Write through the host and mirror it in the model
    task automatic wr(input rcbc_addr_t a, input rcbc_byte_t d);
        host_u.wr(a, d);
        if (a == `RCBC_OFS_CTRL) mCtrl = d;
        if (a == `RCBC_OFS_CAL && mCtrl[2]) mCal = d & 8'h3F;
        if (a == `RCBC_OFS_CFG) mCfg = d;
    endtask

    task automatic rdChk(input rcbc_addr_t a);
        rcbc_byte_t v;
        host_u.rd(a, v);
        chk(32'(v), 32'(expRd(a)));
    endtask

    // Length of the third steady level, as a mode switch may cut the first two; 400 means still
    task automatic gap(output int k);
        logic v;
        k = 0;
        @(posedge sys_clk);
        repeat (3)
        begin
            v = mopOe;
            k = 0;
            while (mopOe === v && k < 400) begin @(posedge sys_clk); k++; end
        end
    endtask

    // Cycles up to the next second pulse, bounded
    task automatic waitTick(output int k);
        k = 0;
        do begin @(posedge sys_clk); k++; end while (secTick !== 1'b1 && k < 70000);
    endtask

    task automatic settle;
        repeat (5) @(posedge sys_clk);
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        void'($urandom(23654));
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rdChk(`RCBC_OFS_CFG);
        rdChk(4'h7);
        chk(mopOe, 0);
        chk(mopOut, 0);
        wr(`RCBC_OFS_CAL, 8'h23);
        rdChk(`RCBC_OFS_CAL);
        wr(`RCBC_OFS_CTRL, 8'h04);
        rdChk(`RCBC_OFS_CTRL);
        repeat (4)
        begin
            wr(`RCBC_OFS_CAL, 8'($urandom) & 8'h3F);
            rdChk(`RCBC_OFS_CAL);
        end
        // Raw wave must ignore correction and the alarm
        wr(`RCBC_OFS_CAL, 8'h2C);
        @(posedge sys_clk);
        alarmActive <= 1'b1;
        gap(n);
        chk(n, half[1]);
        // Sign one, magnitude 12: 28 counts every 16 ticks
        waitTick(n);
        waitTick(n);
        if (n >= 37444 && n <= 37456) n = (32768 << CLOG) / ((1 << CLOG) + 12) * XP;
        chk(n, (32768 << CLOG) / ((1 << CLOG) + 12) * XP);
        @(posedge sys_clk);
        backupLost <= 1'b1;
        settle();
        backupLost <= 1'b0;
        mCal = 0;
        rdChk(`RCBC_OFS_CAL);
        wr(`RCBC_OFS_CTRL, 8'h00);
        gap(n);
        chk(n, 400);
        chk(mopOe, 0);
        wr(`RCBC_OFS_CTRL, 8'h08);
        settle();
        chk(mopOe, 1);
        alarmActive <= 1'b0;
        settle();
        chk(mopOe, 0);
        for (int f = 1; f < 4; f++)
        begin
            wr(`RCBC_OFS_CFG, 8'(f << 5));
            gap(n);
            chk(n, half[f]);
        end
        wr(`RCBC_OFS_CFG, 8'h84);
        settle();
        chk(chargeEn, 1);
        chk(fastChargeEn, 0);
        wr(`RCBC_OFS_CFG, 8'h86);
        settle();
        chk(fastChargeEn, 1);
        rdChk(`RCBC_OFS_STAT);
        vbakAtVdd <= 1'b1;
        settle();
        chk(chargeEn, 0);
        vbakAtVdd <= 1'b0;
        wr(`RCBC_OFS_CFG, 8'h80);
        @(posedge sys_clk);
        vddBelowSw <= 1'b1;
        settle();
        chk(onBackup, 1);
        wr(`RCBC_OFS_STAT, 8'hFF);
        rdChk(`RCBC_OFS_STAT);
        vddBelowSw <= 1'b0;
        settle();
        chk(onBackup, 0);
        wrapUp();
    end

    // Watchdog beyond the two second pulses, yet inside the run budget
    initial
    begin
        #(40 * 95000);
        errCount++;
        wrapUp();
    end
endmodule
